// >>> design/branch_increment_or_execute.sv
// Execute stage for jump, increment, increment-skip and inclusive OR operations
// Operation
// - Jump loads 11-bit target into PC low bits
// - Jump fills PC high bits from latch 6:3
// - Jump takes two instruction cycles
// - Destination bit picks accumulator or file register
// - Increment file stores sum, updates null flag
// - Increment-skip stores sum, nulls next if zero
// - OR literal into accumulator, update null flag
// - OR accumulator with file, selected destination
module branch_increment_or_execute
  import exec_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_issue,
  input wire logic [2:0] i_op,
  input wire logic [FADDR_W-1:0] i_file_addr,
  input wire logic i_dest_sel,
  input wire logic [DATA_W-1:0] i_file_data,
  input wire logic [DATA_W-1:0] i_literal,
  input wire logic [JUMP_W-1:0] i_jump_target,
  input wire logic [LATCH_W-1:0] i_upper_latch,
  output logic o_ready,
  output logic [PC_W-1:0] o_pc,
  output logic [DATA_W-1:0] o_accum,
  output logic o_zero_flag,
  output logic o_file_we,
  output logic [FADDR_W-1:0] o_file_addr,
  output logic [DATA_W-1:0] o_file_wdata
);
  state_e state_r;
  state_e state_nxt;
  logic ready_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [DATA_W-1:0] accum_r;
  logic zero_r;
  logic file_we_r;
  logic [FADDR_W-1:0] file_addr_r;
  logic [DATA_W-1:0] file_wdata_r;
  logic take;
  logic op_jump;
  logic op_skip;
  logic op_file;
  logic op_sets_zero;
  logic to_file;
  logic to_accum;
  logic [DATA_W-1:0] alu_result;
  logic alu_null;
  logic [PC_W-1:0] jump_pc;
  logic [PC_W-1:0] pc_plus_one;
  logic [PC_W-1:0] pc_plus_two;

  // Result path
  exec_alu u_alu
  (
    .i_op(i_op),
    .i_accum(accum_r),
    .i_file_data(i_file_data),
    .i_literal(i_literal),
    .o_result(alu_result),
    .o_null(alu_null)
  );

  // Decode of the presented operation
  assign take = i_issue && (state_r == ST_EXEC);
  assign op_jump = (i_op == OP_JUMP_ABSOLUTE);
  assign op_skip = (i_op == OP_INCREMENT_SKIP_IF_NULL);
  assign op_file = is_file_op(i_op);
  assign op_sets_zero = (i_op == OP_INCREMENT_FILE) || (i_op == OP_OR_LITERAL_INTO_ACCUMULATOR) ||
                        (i_op == OP_OR_ACCUMULATOR_WITH_FILE);
  assign to_file = op_file && (i_dest_sel == DEST_TO_FILE);
  assign to_accum = (op_file && (i_dest_sel != DEST_TO_FILE)) ||
                    (i_op == OP_OR_LITERAL_INTO_ACCUMULATOR);

  // Jump target: latch bits 6:3 above the 11-bit immediate
  assign jump_pc = {i_upper_latch[LATCH_HI:LATCH_LO], i_jump_target};
  assign pc_plus_one = pc_r + NEXT_STEP;
  assign pc_plus_two = pc_r + SKIP_STEP;

  // Second cycle for a jump, or a null cycle after a zero increment-skip
  always_comb
  begin
    state_nxt = ST_EXEC;
    case (state_r)
      ST_EXEC:
        if (take && (op_jump || (op_skip && alu_null)))
          state_nxt = ST_FLUSH;
      ST_FLUSH:
        state_nxt = ST_EXEC;
      default:
        state_nxt = ST_EXEC;
    endcase
  end

  // State register, with ready kept in its own flop so the output needs no decode
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_r <= ST_EXEC;
      ready_r <= 1'h1;
    end
    else
    begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == ST_EXEC);
    end
  end

  // Program counter next value
  always_comb
  begin
    pc_nxt = pc_r;
    if (take)
    begin
      if (op_jump)
        pc_nxt = jump_pc;
      else if (op_skip && alu_null)
        pc_nxt = pc_plus_two;
      else
        pc_nxt = pc_plus_one;
    end
  end

  // Program counter
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      pc_r <= PC_RESET;
    else
      pc_r <= pc_nxt;
  end

  // Accumulator
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      accum_r <= ACCUM_RESET;
    else if (take && to_accum)
      accum_r <= alu_result;
  end

  // Null-result flag; jump and increment-skip leave it alone
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      zero_r <= ZERO_RESET;
    else if (take && op_sets_zero)
      zero_r <= alu_null;
  end

  // File register write-back, one cycle strobe
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      file_we_r <= 1'h0;
      file_addr_r <= {FADDR_W{1'h0}};
      file_wdata_r <= ACCUM_RESET;
    end
    else
    begin
      file_we_r <= take && to_file;
      if (take && to_file)
      begin
        file_addr_r <= i_file_addr;
        file_wdata_r <= alu_result;
      end
    end
  end

  // Outputs straight from flip-flops
  assign o_ready = ready_r;
  assign o_pc = pc_r;
  assign o_accum = accum_r;
  assign o_zero_flag = zero_r;
  assign o_file_we = file_we_r;
  assign o_file_addr = file_addr_r;
  assign o_file_wdata = file_wdata_r;

  // Checks on the execute behaviour
  a_jump_pc_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && op_jump |=> o_pc == $past(jump_pc))
    else $error("jump did not load the target");

  a_jump_two_cycles: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && op_jump |=> !o_ready ##1 o_ready)
    else $error("jump did not take two cycles");

  a_jump_no_flags: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && op_jump |=> $stable(o_zero_flag) && $stable(o_accum) && !o_file_we)
    else $error("jump changed flag or data");

  a_dest_accum: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && op_file && !i_dest_sel |=> o_accum == $past(alu_result) && !o_file_we)
    else $error("accumulator destination not honoured");

  a_dest_file: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && to_file |=> o_file_we && o_file_addr == $past(i_file_addr) && $stable(o_accum))
    else $error("file destination not honoured");

  a_increment_sum: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && i_op == OP_INCREMENT_FILE && to_file |=>
      o_file_wdata == DATA_W'($past(i_file_data) + INC_STEP))
    else $error("increment stored wrong sum");

  a_skip_zero_null: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && op_skip && alu_null |=> !o_ready && o_pc == $past(pc_plus_two) ##1 o_ready)
    else $error("zero increment-skip did not skip");

  a_skip_nonzero_run: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && op_skip && !alu_null |=> o_ready && o_pc == $past(pc_plus_one) && $stable(o_zero_flag))
    else $error("nonzero increment-skip misbehaved");

  a_or_literal_acc: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && i_op == OP_OR_LITERAL_INTO_ACCUMULATOR |=> o_accum == ($past(o_accum) | $past(i_literal)))
    else $error("literal OR wrong");

  a_or_file_acc: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && i_op == OP_OR_ACCUMULATOR_WITH_FILE && !i_dest_sel |=>
      o_accum == ($past(o_accum) | $past(i_file_data)))
    else $error("file OR wrong");

  a_null_flag_value: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    take && op_sets_zero |=> o_zero_flag == ($past(alu_result) == ACCUM_RESET))
    else $error("null flag does not match result");
endmodule // branch_increment_or_execute

// >>> design/exec_pkg.sv
// Shared widths, reset values, operation and state codes for the execute block
package exec_pkg;
  localparam int PC_W = 15;
  localparam int JUMP_W = 11;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int LATCH_W = 7;
  localparam int LATCH_HI = 6;
  localparam int LATCH_LO = 3;
  localparam logic DEST_TO_FILE = 1'h1;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'h0;
  localparam logic [PC_W-1:0] NEXT_STEP = 15'h0001;
  localparam logic [PC_W-1:0] SKIP_STEP = 15'h0002;
  localparam logic [DATA_W-1:0] INC_STEP = 8'h01;

  typedef enum logic [2:0]
  {
    OP_JUMP_ABSOLUTE = 3'h0,
    OP_INCREMENT_FILE = 3'h1,
    OP_INCREMENT_SKIP_IF_NULL = 3'h2,
    OP_OR_LITERAL_INTO_ACCUMULATOR = 3'h3,
    OP_OR_ACCUMULATOR_WITH_FILE = 3'h4
  } op_e;

  typedef enum logic [1:0]
  {
    ST_EXEC = 2'h1,
    ST_FLUSH = 2'h2
  } state_e;

  // True for operations that read the addressed file register
  function automatic logic is_file_op(input logic [2:0] op);
    is_file_op = (op == OP_INCREMENT_FILE) || (op == OP_INCREMENT_SKIP_IF_NULL) ||
                 (op == OP_OR_ACCUMULATOR_WITH_FILE);
  endfunction

  // True when a byte is all zeros
  function automatic logic is_null(input logic [DATA_W-1:0] v);
    is_null = (v == ACCUM_RESET);
  endfunction
endpackage

// >>> design/exec_alu.sv
// Combinational result path for increment and inclusive OR operations
module exec_alu
  import exec_pkg::*;
(
  input wire logic [2:0] i_op,
  input wire logic [DATA_W-1:0] i_accum,
  input wire logic [DATA_W-1:0] i_file_data,
  input wire logic [DATA_W-1:0] i_literal,
  output logic [DATA_W-1:0] o_result,
  output logic o_null
);
  // Select the result by operation
  always_comb
  begin
    case (i_op)
      OP_INCREMENT_FILE,
      OP_INCREMENT_SKIP_IF_NULL:
        o_result = i_file_data + INC_STEP;
      OP_OR_LITERAL_INTO_ACCUMULATOR:
        o_result = i_accum | i_literal;
      OP_OR_ACCUMULATOR_WITH_FILE:
        o_result = i_accum | i_file_data;
      default:
        o_result = ACCUM_RESET;
    endcase
    o_null = is_null(o_result);
  end
endmodule // exec_alu

// >>> tb/branch_increment_or_execute_test.sv
// Self-checking testbench for the jump, increment, increment-skip and OR execute block
module branch_increment_or_execute_test import exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_ref_clk;
  logic i_sys_rst;
  logic i_issue;
  logic [2:0] i_op;
  logic [FADDR_W-1:0] i_file_addr;
  logic i_dest_sel;
  logic [DATA_W-1:0] i_file_data;
  logic [DATA_W-1:0] i_literal;
  logic [JUMP_W-1:0] i_jump_target;
  logic [LATCH_W-1:0] i_upper_latch;
  logic o_ready;
  logic [PC_W-1:0] o_pc;
  logic [DATA_W-1:0] o_accum;
  logic o_zero_flag;
  logic o_file_we;
  logic [FADDR_W-1:0] o_file_addr;
  logic [DATA_W-1:0] o_file_wdata;
  int fail_count;
  int comparisons;
  logic [PC_W-1:0] exp_pc;

  branch_increment_or_execute dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_issue(i_issue), .i_op(i_op),
    .i_file_addr(i_file_addr), .i_dest_sel(i_dest_sel), .i_file_data(i_file_data),
    .i_literal(i_literal), .i_jump_target(i_jump_target), .i_upper_latch(i_upper_latch),
    .o_ready(o_ready), .o_pc(o_pc), .o_accum(o_accum), .o_zero_flag(o_zero_flag),
    .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata)
  );

  // Free-running 100 MHz clock
  initial
  begin
    i_ref_clk = 1'h0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // Compares one value and reports a difference
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run
  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Presents one instruction for one take edge, then settles past that edge
  task automatic run(input logic [2:0] op, input logic [6:0] addr, input logic d, input logic [7:0] data,
                     input logic [7:0] lit);
    @(posedge i_ref_clk);
    i_issue <= 1'h1;
    i_op <= op;
    i_file_addr <= addr;
    i_dest_sel <= d;
    i_file_data <= data;
    i_literal <= lit;
    @(posedge i_ref_clk);
    i_issue <= 1'h0;
    #1;
  endtask

  // Checks the architectural outputs together
  task automatic state_is(input logic [7:0] acc, input logic z, input logic rdy, input logic we);
    chk("pc", 16'(o_pc), 16'(exp_pc));
    chk("accum", 16'(o_accum), 16'(acc));
    chk("zero_flag", 16'(o_zero_flag), 16'(z));
    chk("ready", 16'(o_ready), 16'(rdy));
    chk("file_we", 16'(o_file_we), 16'(we));
  endtask

  // Jump target from latch bits 6:3, then an ignored request in the second cycle
  task automatic t_jump();
    @(posedge i_ref_clk);
    i_issue <= 1'h1;
    i_op <= 3'h0;
    i_jump_target <= 11'h7FF;
    i_upper_latch <= 7'h5A;
    @(posedge i_ref_clk);
    i_op <= 3'h3;
    i_literal <= 8'hFF;
    #1;
    exp_pc = 15'h5FFF;
    state_is(8'h00, 1'h0, 1'h0, 1'h0);
    @(posedge i_ref_clk);
    i_issue <= 1'h0;
    #1;
    state_is(8'h00, 1'h0, 1'h1, 1'h0);
  endtask

  // Increment to both destinations, with wrap to zero
  task automatic t_increment();
    run(3'h1, 7'h7F, 1'h1, 8'hFF, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    state_is(8'h00, 1'h1, 1'h1, 1'h1);
    chk("file_addr", 16'(o_file_addr), 16'h007F);
    chk("file_wdata", 16'(o_file_wdata), 16'h0000);
    @(posedge i_ref_clk);
    #1;
    chk("file_we", 16'(o_file_we), 16'h0000);
    run(3'h1, 7'h05, 1'h0, 8'h10, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    state_is(8'h11, 1'h0, 1'h1, 1'h0);
  endtask

  // Increment-skip: zero sum nulls the next slot, nonzero sum does not
  task automatic t_skip();
    run(3'h2, 7'h12, 1'h0, 8'hFF, 8'h00);
    exp_pc = exp_pc + 15'h0002;
    state_is(8'h00, 1'h0, 1'h0, 1'h0);
    @(posedge i_ref_clk);
    #1;
    state_is(8'h00, 1'h0, 1'h1, 1'h0);
    run(3'h2, 7'h33, 1'h1, 8'h01, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    state_is(8'h00, 1'h0, 1'h1, 1'h1);
    chk("file_wdata", 16'(o_file_wdata), 16'h0002);
    chk("file_addr", 16'(o_file_addr), 16'h0033);
  endtask

  // OR literal into the accumulator, null and non-null results
  task automatic t_or_literal();
    run(3'h3, 7'h00, 1'h1, 8'hFF, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    state_is(8'h00, 1'h1, 1'h1, 1'h0);
    run(3'h3, 7'h00, 1'h1, 8'h00, 8'hA5);
    exp_pc = exp_pc + 15'h0001;
    state_is(8'hA5, 1'h0, 1'h1, 1'h0);
  endtask

  // OR accumulator with a file register to both destinations
  task automatic t_or_file();
    run(3'h4, 7'h44, 1'h1, 8'h5A, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    state_is(8'hA5, 1'h0, 1'h1, 1'h1);
    chk("file_wdata", 16'(o_file_wdata), 16'h00FF);
    run(3'h4, 7'h45, 1'h0, 8'h42, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    state_is(8'hE7, 1'h0, 1'h1, 1'h0);
  endtask

  // Main sequence: reset, then each scenario
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    exp_pc = 15'h0000;
    i_sys_rst = 1'h1;
    i_issue = 1'h0;
    i_op = 3'h0;
    i_file_addr = 7'h00;
    i_dest_sel = 1'h0;
    i_file_data = 8'h00;
    i_literal = 8'h00;
    i_jump_target = 11'h000;
    i_upper_latch = 7'h00;
    repeat (20) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    #1;
    state_is(8'h00, 1'h0, 1'h1, 1'h0);
    t_jump();
    t_increment();
    t_skip();
    t_or_literal();
    t_or_file();
    give_verdict();
  end

  // Watchdog well beyond the roughly 40 cycles the scenarios need
  initial
  begin
    repeat (2000) @(posedge i_ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule // branch_increment_or_execute_test
